// file: inc/spe_pkg.sv
/*
 * spe_pkg: shared constants of the serial programming entry block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package spe_pkg;

   // ************************************************
   // entry key and shift widths
   // ************************************************
   localparam int          KEY_W         = 32;            // entry key length in bits
   localparam logic [31:0] KEY_DEFAULT   = 32'h5a3c_c3a5; // arbitrary value, not a real key
   localparam int          TX_W          = 8;             // bits per returned data word
   localparam int          SYS_SYNC_W    = 5;             // levels crossing into sys_clk
   localparam int          LINK_SYNC_W   = 2;             // levels crossing into the link clock

   // ************************************************
   // positions inside the sys_clk synchroniser bus
   // ************************************************
   localparam int          SY_LOW        = 0;             // master clear at input low level
   localparam int          SY_HV         = 1;             // master clear at programming voltage
   localparam int          SY_DATA       = 2;             // data pin level
   localparam int          SY_KEY        = 3;             // key match toggle
   localparam int          SY_ACK        = 4;             // transmit done toggle

   // positions inside the link synchroniser bus
   localparam int          LK_RST        = 0;             // reset into link domain
   localparam int          LK_REQ        = 1;             // transmit request toggle

   // ************************************************
   // entry state
   // ************************************************
   typedef enum logic [1:0] {
      SPE_RUN,
      SPE_HV,
      SPE_LV
   } spe_state_t;

endpackage

// file: hdl/spe_sync.sv
/*
 * spe_sync: two flip-flop level synchroniser, one lane per bit.
 * assumes each lane is a slow level or a toggle, never a multi-bit word.
 */
`timescale 1ns/10ps
`default_nettype none

module spe_sync #(
   parameter int W = 1                          // number of lanes
) (
   input  wire logic         clk,               // destination clock
   input  wire logic         clear,             // synchronous clear, active high
   input  wire logic [W-1:0] d,                 // asynchronous levels
   output logic      [W-1:0] q                  // synchronised levels
);

   logic [W-1:0] meta_r;                        // first stage, read only by q

   initial begin
      if (W < 1) $error("spe_sync: W must be at least 1");
   end

   // two stages, cleared together
   always_ff @(posedge clk) begin
      if (clear) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule
`default_nettype wire

// file: hdl/spe_entry.sv
/*
 * spe_entry: program/verify entry logic behind the serial programming pins.
 * assumes master clear arrives as two comparator levels, the programming
 * clock pin is a free clock port, and config bits are on sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module spe_entry
   import spe_pkg::*;
#(
   parameter int              KEY_BITS  = spe_pkg::KEY_W,       // key length
   parameter logic [31:0]     ENTRY_KEY = spe_pkg::KEY_DEFAULT, // arbitrary key value
   parameter int              TX_BITS   = spe_pkg::TX_W         // returned word width
) (
   input  wire logic               sys_clk,                 // system clock, 125 MHz
   input  wire logic               reset,                   // synchronous reset, high
   input  wire logic               prog_clock_pin,          // programmer clock
   input  wire logic               prog_data_pin_in,        // data pin level
   output logic                    prog_data_pin_out,       // data pin drive value
   output logic                    prog_data_pin_oe,        // data pin drive enable
   input  wire logic               master_clear_low,        // pin at input_low_level
   input  wire logic               master_clear_high_volt,  // pin at high_prog_voltage_level
   input  wire logic               low_voltage_prog_enable, // config enable bit
   input  wire logic               clear_reset_cfg,         // user master clear reset setting
   input  wire logic               lvp_clear_req,           // request to program enable bit 0
   input  wire logic               tx_start,                // pulse, send tx_data
   input  wire logic [TX_BITS-1:0] tx_data,                 // word to return
   output logic                    tx_busy,                 // word in flight
   output logic                    pv_mode,                 // program/verify active
   output logic                    hv_session,              // entered by high voltage
   output logic                    nvm_prog_en,             // memory programming open
   output logic                    clear_reset_en,          // master clear reset function on
   output logic                    lvp_clear_wr             // pulse, clear enable bit now
);

   import spe_pkg::*;

   initial begin
      if (KEY_BITS < 2 || KEY_BITS > 32) $error("spe_entry: KEY_BITS must be 2..32");
      if (TX_BITS < 2 || TX_BITS > 32) $error("spe_entry: TX_BITS must be 2..32");
   end

   // ************************************************
   // declarations
   // ************************************************
   logic [SYS_SYNC_W-1:0]  sys_s;
   logic [LINK_SYNC_W-1:0] lk_s;
   logic                   low_s, hv_s, data_s, key_s, ack_s;
   logic                   hv_seen_r, key_seen_r, ack_seen_r;
   logic                   hv_rise, key_evt, ack_evt, tx_accept;
   spe_state_t             state_r, state_nxt;
   logic                   req_tgl_r;
   logic [TX_BITS-1:0]     tx_hold_r;
   // link domain
   logic                   rst_lk, req_s, req_seen_r, tx_go;
   logic [KEY_BITS-1:0]    key_sh_r, key_nxt;
   logic                   key_tgl_r, ack_tgl_r, key_hit;
   logic [TX_BITS-1:0]     tx_sh_r;
   logic [5:0]             tx_cnt_r;

   // ************************************************
   // sys_clk crossings
   // ************************************************
   spe_sync #(.W(SYS_SYNC_W)) u_sys_sync (
      .clk   (sys_clk),
      .clear (reset),
      .d     ({ack_tgl_r, key_tgl_r, prog_data_pin_in, master_clear_high_volt, master_clear_low}),
      .q     (sys_s)
   );

   assign low_s  = sys_s[SY_LOW];
   assign hv_s   = sys_s[SY_HV];
   assign data_s = sys_s[SY_DATA];
   assign key_s  = sys_s[SY_KEY];
   assign ack_s  = sys_s[SY_ACK];

   // edge detection on synchronised levels
   assign hv_rise   = hv_s & ~hv_seen_r;
   assign key_evt   = key_s ^ key_seen_r;
   assign ack_evt   = ack_s ^ ack_seen_r;
   assign tx_accept = tx_start & pv_mode & ~tx_busy;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         hv_seen_r  <= 1'b0;
         key_seen_r <= 1'b0;
         ack_seen_r <= 1'b0;
      end else begin
         hv_seen_r  <= hv_s;
         key_seen_r <= key_s;
         ack_seen_r <= ack_s;
      end
   end

   // ************************************************
   // entry state machine
   // ************************************************
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SPE_RUN: begin
            if (hv_rise && !data_s) begin
               state_nxt = SPE_HV;
            end else if (key_evt && low_voltage_prog_enable && low_s) begin
               state_nxt = SPE_LV;
            end
         end
         SPE_HV: begin
            if (!hv_s) begin
               state_nxt = SPE_RUN;
            end
         end
         SPE_LV: begin
            if (!low_s) begin
               state_nxt = SPE_RUN;
            end
         end
         default: state_nxt = SPE_RUN;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_r <= SPE_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ************************************************
   // mode outputs
   // ************************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pv_mode        <= 1'b0;
         hv_session     <= 1'b0;
         nvm_prog_en    <= 1'b0;
         clear_reset_en <= 1'b0;
         lvp_clear_wr   <= 1'b0;
      end else begin
         pv_mode        <= (state_nxt != SPE_RUN);
         hv_session     <= (state_nxt == SPE_HV);
         nvm_prog_en    <= pv_mode;
         clear_reset_en <= clear_reset_cfg | low_voltage_prog_enable;
         lvp_clear_wr   <= lvp_clear_req & (state_r == SPE_HV);
      end
   end

   // ************************************************
   // transmit request, sys side
   // ************************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         tx_busy   <= 1'b0;
         req_tgl_r <= 1'b0;
         tx_hold_r <= '0;
      end else begin
         if (tx_accept) begin
            tx_hold_r <= tx_data;
            req_tgl_r <= ~req_tgl_r;
         end
         if (tx_accept) begin
            tx_busy <= 1'b1;
         end else if (ack_evt) begin
            tx_busy <= 1'b0;
         end
      end
   end

   // ************************************************
   // link domain crossings
   // ************************************************
   spe_sync #(.W(LINK_SYNC_W)) u_link_sync (
      .clk   (prog_clock_pin),
      .clear (1'b0),
      .d     ({req_tgl_r, reset}),
      .q     (lk_s)
   );

   assign rst_lk = lk_s[LK_RST];
   assign req_s  = lk_s[LK_REQ];
   assign tx_go  = req_s ^ req_seen_r;

   // ************************************************
   // key shifter, msb first, on the programmer clock
   // ************************************************
   assign key_nxt = {key_sh_r[KEY_BITS-2:0], prog_data_pin_in};
   assign key_hit = (key_nxt == ENTRY_KEY[KEY_BITS-1:0]);

   always_ff @(posedge prog_clock_pin) begin
      if (rst_lk) begin
         key_sh_r  <= '0;
         key_tgl_r <= 1'b0;
      end else if (!prog_data_pin_oe) begin
         key_sh_r  <= key_nxt;
         key_tgl_r <= key_tgl_r ^ key_hit;
      end
   end

   // ************************************************
   // data return, driven only while a word is shifted out
   // ************************************************
   always_ff @(posedge prog_clock_pin) begin
      if (rst_lk) begin
         req_seen_r        <= 1'b0;
         ack_tgl_r         <= 1'b0;
         tx_sh_r           <= '0;
         tx_cnt_r          <= '0;
         prog_data_pin_out <= 1'b0;
         prog_data_pin_oe  <= 1'b0;
      end else begin
         req_seen_r <= req_s;
         if (tx_go) begin
            tx_sh_r           <= tx_hold_r;
            prog_data_pin_out <= tx_hold_r[TX_BITS-1];
            prog_data_pin_oe  <= 1'b1;
            tx_cnt_r          <= 6'(TX_BITS - 1);
         end else if (tx_cnt_r != '0) begin
            tx_sh_r           <= {tx_sh_r[TX_BITS-2:0], 1'b0};
            prog_data_pin_out <= tx_sh_r[TX_BITS-2];
            tx_cnt_r          <= tx_cnt_r - 6'h01;
         end else if (prog_data_pin_oe) begin
            prog_data_pin_oe  <= 1'b0;
            prog_data_pin_out <= 1'b0;
            ack_tgl_r         <= ~ack_tgl_r;
         end
      end
   end

   // ************************************************
   // assertions, sys_clk domain
   // ************************************************
   sequence s_hv_step;
      hv_rise && !data_s && (state_r == SPE_RUN);
   endsequence

   property p_hv_entry;
      @(posedge sys_clk) disable iff (reset)
      s_hv_step |=> (state_r == SPE_HV) ##1 (pv_mode && hv_session);
   endproperty
   a_hv_entry: assert property (p_hv_entry) else $error("hv entry missed");

   property p_lv_needs_enable;
      @(posedge sys_clk) disable iff (reset)
      (state_r == SPE_RUN) ##1 (state_r == SPE_LV) |-> $past(low_voltage_prog_enable);
   endproperty
   a_lv_needs_enable: assert property (p_lv_needs_enable) else $error("lv entry without enable");

   property p_lv_ignored;
      @(posedge sys_clk) disable iff (reset)
      (!low_voltage_prog_enable && state_r != SPE_LV) |=> (state_r != SPE_LV);
   endproperty
   a_lv_ignored: assert property (p_lv_ignored) else $error("lv entry while disabled");

   sequence s_key_step;
      key_evt && low_voltage_prog_enable && low_s && !hv_rise && (state_r == SPE_RUN);
   endsequence

   property p_lv_entry;
      @(posedge sys_clk) disable iff (reset)
      s_key_step |=> (state_r == SPE_LV) ##1 pv_mode ##1 nvm_prog_en;
   endproperty
   a_lv_entry: assert property (p_lv_entry) else $error("lv entry missed");

   property p_lv_exit;
      @(posedge sys_clk) disable iff (reset)
      (state_r == SPE_LV) && !low_s |=> !pv_mode ##1 !nvm_prog_en;
   endproperty
   a_lv_exit: assert property (p_lv_exit) else $error("lv mode outlived release");

   property p_reset_forced;
      @(posedge sys_clk) disable iff (reset)
      low_voltage_prog_enable |=> clear_reset_en;
   endproperty
   a_reset_forced: assert property (p_reset_forced) else $error("reset function not forced");

   property p_lvp_clear_hv;
      @(posedge sys_clk) disable iff (reset)
      lvp_clear_wr |-> $past(state_r == SPE_HV) && $past(lvp_clear_req);
   endproperty
   a_lvp_clear_hv: assert property (p_lvp_clear_hv) else $error("enable cleared outside hv");

   property p_nvm_follows;
      @(posedge sys_clk) disable iff (reset)
      $rose(pv_mode) |-> !nvm_prog_en ##1 nvm_prog_en;
   endproperty
   a_nvm_follows: assert property (p_nvm_follows) else $error("memory access not opened");

   // ************************************************
   // assertions, link domain
   // ************************************************
   property p_tx_drive;
      @(posedge prog_clock_pin) disable iff (rst_lk)
      tx_go |=> prog_data_pin_oe [*8] ##1 !prog_data_pin_oe;
   endproperty
   a_tx_drive: assert property (p_tx_drive) else $error("data pin drive length wrong");

   property p_key_toggle;
      @(posedge prog_clock_pin) disable iff (rst_lk)
      (key_hit && !prog_data_pin_oe) |=> (key_tgl_r != $past(key_tgl_r));
   endproperty
   a_key_toggle: assert property (p_key_toggle) else $error("key match not signalled");

endmodule
`default_nettype wire

// file: sim/spe_programmer.sv
/*
 * spe_programmer: behavioural external programmer for the entry block.
 * assumes the bench resolves the data wire from both drivers.
 */
`timescale 1ns/10ps
`default_nettype none

module spe_programmer (
   input  wire logic data_wire,      // resolved data pin level
   input  wire logic dev_drive,      // device is driving the data pin
   output logic      prog_clock_pin, // programming clock, idle low
   output logic      data_val,       // value we drive on the data pin
   output logic      data_en,        // we drive the data pin
   output logic      mclr_low,       // master clear at input low level
   output logic      mclr_hv         // master clear at programming voltage
);
   // ************************************************
   // pin sequences
   // ************************************************
   // clock stands still between frames
   initial begin
      prog_clock_pin = 1'b0;
      data_val = 1'b0;
      data_en = 1'b1;
      mclr_low = 1'b0;
      mclr_hv = 1'b0;
   end

   // one clock pulse, data set up well before the rise
   task automatic pulse();
      #15 prog_clock_pin = 1'b1;
      #15 prog_clock_pin = 1'b0;
   endtask

   task automatic clocks(input int n);
      repeat (n) pulse();
   endtask

   // clock low and data set to dat, then raise to programming voltage
   task automatic hv_entry(input logic dat);
      prog_clock_pin = 1'b0;
      data_val = dat;
      #100 mclr_hv = 1'b1;
   endtask

   task automatic release_all();
      mclr_hv = 1'b0;
      mclr_low = 1'b0;
      data_val = 1'b0;
   endtask

   // master clear low first, then key msb first, held low after
   task automatic lv_key(input logic [31:0] k);
      mclr_low = 1'b1;
      #100;
      for (int i = 31; i >= 0; i--) begin
         data_val = k[i];
         pulse();
      end
   endtask

   // release the pin and sample returned bits on the falling edge
   task automatic recv(output logic [7:0] w, output int n);
      w = 8'h00;
      n = 0;
      data_en = 1'b0;
      repeat (14) begin
         pulse();
         if (dev_drive === 1'b1) begin
            w = {w[6:0], data_wire};
            n++;
         end
      end
      data_en = 1'b1;
   endtask
endmodule

`default_nettype wire

// file: sim/tb.sv
/*
 * tb: self-checking bench for spe_entry with a programmer model.
 * assumes spe_pkg and spe_programmer are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module tb;
   import spe_pkg::*;
   logic        sys_clk = 0, reset = 1, lvp_en = 0, cfg = 0, clr_req = 0, tx_start = 0, float_r = 0;
   logic [7:0]  tx_data = 8'h00;
   logic        prog_clock_pin, prg_val, prg_en, mclr_low, mclr_hv, dat_out, dat_oe;
   logic        tx_busy, pv_mode, hv_session, nvm_prog_en, clear_reset_en, lvp_clear_wr;
   logic [31:0] seed = 32'd48929;
   int          errors = 0, comparisons = 0, cycles = 0, wr_cnt = 0;
   logic [7:0]  exp_q[$];
   // released data wire flips every cycle so nothing stale reads back
   wire logic   data_wire = dat_oe ? dat_out : (prg_en ? prg_val : float_r);

   spe_entry i_spe_entry (.sys_clk(sys_clk), .reset(reset), .prog_clock_pin(prog_clock_pin),
      .prog_data_pin_in(data_wire), .prog_data_pin_out(dat_out), .prog_data_pin_oe(dat_oe),
      .master_clear_low(mclr_low), .master_clear_high_volt(mclr_hv), .low_voltage_prog_enable(lvp_en),
      .clear_reset_cfg(cfg), .lvp_clear_req(clr_req), .tx_start(tx_start), .tx_data(tx_data),
      .tx_busy(tx_busy), .pv_mode(pv_mode), .hv_session(hv_session), .nvm_prog_en(nvm_prog_en),
      .clear_reset_en(clear_reset_en), .lvp_clear_wr(lvp_clear_wr));

   spe_programmer i_spe_programmer (.data_wire(data_wire), .dev_drive(dat_oe),
      .prog_clock_pin(prog_clock_pin), .data_val(prg_val), .data_en(prg_en),
      .mclr_low(mclr_low), .mclr_hv(mclr_hv));

   // ************************************************
   // clock, watchdog and pulse counting
   // ************************************************
   always #4 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      float_r <= ~float_r;
      cycles <= cycles + 1;
      if (lvp_clear_wr === 1'b1) wr_cnt <= wr_cnt + 1;
      if (cycles == 40000) begin
         errors = errors + 1;
         wrap_up();
      end
   end

   // ************************************************
   // helpers
   // ************************************************
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk1(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: word %h not %h", $time, got, exp);
      end
   endtask

   // mode change comes within a bounded number of cycles
   task automatic wait_mode(input logic exp);
      int i;
      i = 0;
      while (pv_mode !== exp && i < 30) begin
         @(negedge sys_clk);
         i++;
      end
      @(negedge sys_clk);
      chk1(pv_mode, exp, "mode");
      chk1(nvm_prog_en, exp, "memory programming");
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic clear_req();
      @(negedge sys_clk);
      clr_req = 1'b1;
      @(negedge sys_clk);
      clr_req = 1'b0;
      idle(3);
   endtask

   // return one word through the data pin
   task automatic send(input logic [7:0] d);
      logic [7:0] w;
      int         n;
      int         i;
      @(negedge sys_clk);
      tx_data = d;
      tx_start = 1'b1;
      exp_q.push_back(d);
      @(negedge sys_clk);
      tx_start = 1'b0;
      chk1(tx_busy, 1'b1, "busy");
      i_spe_programmer.recv(w, n);
      i = 0;
      while (tx_busy !== 1'b0 && i < 30) begin
         @(negedge sys_clk);
         i++;
      end
      chk1(tx_busy, 1'b0, "busy end");
      chk1(n == TX_W, 1'b1, "bit count");
      chk8(w, exp_q.pop_front());
   endtask

   task automatic wrap_up();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      fork
         idle(16);
         i_spe_programmer.clocks(6);
      join
      // release off the sampling edge, the join lands on a rising edge
      @(negedge sys_clk);
      reset = 1'b0;
      i_spe_programmer.clocks(4);
      idle(3);
      for (int i = 0; i < 4; i++) begin
         {lvp_en, cfg} = i[1:0];
         idle(3);
         chk1(clear_reset_en, lvp_en | cfg, "reset function");
      end
      lvp_en = 1'b0;
      cfg = 1'(xs());
      i_spe_programmer.hv_entry(1'b1);
      idle(30);
      chk1(pv_mode, 1'b0, "entry with data high");
      i_spe_programmer.release_all();
      idle(10);
      i_spe_programmer.hv_entry(1'b0);
      wait_mode(1'b1);
      chk1(hv_session, 1'b1, "high voltage session");
      clear_req();
      chk1(wr_cnt == 1, 1'b1, "enable clear");
      for (int i = 0; i < 3; i++) send(8'(xs()));
      i_spe_programmer.release_all();
      wait_mode(1'b0);
      lvp_en = 1'b1;
      i_spe_programmer.lv_key(KEY_DEFAULT ^ (32'h1 << (xs() & 32'h1f)));
      idle(30);
      chk1(pv_mode, 1'b0, "wrong key");
      i_spe_programmer.release_all();
      idle(10);
      i_spe_programmer.lv_key(KEY_DEFAULT);
      wait_mode(1'b1);
      chk1(hv_session, 1'b0, "low voltage session");
      clear_req();
      chk1(wr_cnt == 1, 1'b1, "enable clear refused");
      send(8'(xs()));
      i_spe_programmer.release_all();
      wait_mode(1'b0);
      lvp_en = 1'b0;
      i_spe_programmer.lv_key(KEY_DEFAULT);
      idle(30);
      chk1(pv_mode, 1'b0, "disabled entry");
      i_spe_programmer.release_all();
      idle(10);
      wrap_up();
   end
endmodule

`default_nettype wire
